/* shared/idc_pkg.sv */
`default_nettype none
package idc_pkg;
	// Host address decode
	localparam int unsigned ADDR_W      = 10;
	localparam int unsigned ADDR_SEL    = 9;
	localparam int unsigned BASE_MSB    = 8;
	localparam int unsigned BASE_LSB    = 3;
	localparam int unsigned SW_W        = 6;
	localparam logic [5:0]  SW_FACTORY  = 6'h20;
	localparam logic [9:0]  BASE_LOWEST = 10'h200;
	localparam logic [9:0]  BASE_TOP    = 10'h3ff;
	// Port offsets inside the eight-byte block
	localparam logic [2:0]  OFS_ISO_LO  = 3'h0;
	localparam logic [2:0]  OFS_ISO_HI  = 3'h1;
	localparam logic [2:0]  OFS_PLN_LO  = 3'h2;
	localparam logic [2:0]  OFS_PLN_HI  = 3'h3;
	localparam logic [2:0]  OFS_CNT0    = 3'h4;
	localparam logic [2:0]  OFS_CTRL    = 3'h7;
	// Timer control byte fields
	localparam int unsigned CW_SEL_LSB  = 6;
	localparam int unsigned CW_RW_LSB   = 4;
	localparam logic [1:0]  CW_READBACK = 2'h3;
	localparam logic [1:0]  RW_LATCH    = 2'h0;
	localparam logic [1:0]  RW_LSB      = 2'h1;
	localparam logic [1:0]  RW_MSB      = 2'h2;
	localparam logic [1:0]  RW_BOTH     = 2'h3;
	localparam int unsigned CNT_W       = 16;
	localparam int unsigned CNT_N       = 3;
	// Timing
	localparam int unsigned CLK_HZ      = 20000000;
	localparam int unsigned BASE_HZ     = 2000000;
	localparam int unsigned BASE_DIV    = CLK_HZ / BASE_HZ;
	localparam int unsigned N_LO_IRQ    = 5;
	localparam int unsigned N_HI_IRQ    = 7;
endpackage
`default_nettype wire

/* rtl/idc_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module idc_counter #(
	parameter int unsigned W = 16
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic         tick,
	input  wire logic         gate,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic      [W-1:0] count_q,
	output logic              term_q,
	output logic              armed_q
);
	typedef struct packed {
		logic [W-1:0] count;
		logic [W-1:0] reload;
		logic         term;
		logic         armed;
	} idc_cnt_state_t;

	idc_cnt_state_t s_q;
	idc_cnt_state_t s_d;

	// Reload of zero wraps through all ones, giving the full 2^W span
	always_comb begin
		s_d = s_q;
		s_d.term = 1'b0;
		if (load) begin
			s_d.count = load_val;
			s_d.reload = load_val;
			s_d.armed = 1'b1;
		end else if (s_q.armed && tick && gate) begin
			if (s_q.count == W'(1)) begin
				s_d.count = s_q.reload;
				s_d.term = 1'b1;
			end else begin
				s_d.count = s_q.count - W'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign count_q = s_q.count;
	assign term_q  = s_q.term;
	assign armed_q = s_q.armed;

	AST_RELOAD_AT_TERM: assert property (@(posedge mclk) disable iff (!nrst) term_q |-> count_q == s_q.reload && $past(count_q) == W'(1))
		else $error("counter did not reload at terminal count");
endmodule
`default_nettype wire

/* rtl/idc_core.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Eight byte ports, base 200h..3FFh
// - A8..A3 compared to switch, open means one
// - A9 must be high to select
// - Factory switch setting gives base 300h
// - Sixteen isolated and plain inputs, outputs each
// - Host uses byte-wide I/O cycles only
// - Three 16-bit down counters, counter one clocked by counter two
// - 2 MHz clocks counter two, feeds one
// - Counter zero clock, gate from header
// - Lower IRQ external, higher IRQ timer
// - Both IRQ lines independent, may coincide
// - Four selectable sources, rising or falling edge
// - Sources: isolated 0/1, plain 0/1
// - Offsets 0-3 data, 4-6 counters, 7 control
module idc_core (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [9:0]  sa,
	input  wire logic        ior_n,
	input  wire logic        iow_n,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe_n,
	input  wire logic [5:0]  base_select_switch,
	input  wire logic [15:0] iso_in,
	input  wire logic [15:0] plain_in,
	output logic      [15:0] iso_out,
	output logic      [15:0] plain_out,
	input  wire logic        free_counter_clk,
	input  wire logic        free_counter_gate,
	input  wire logic [1:0]  lower_irq_source_jumper,
	input  wire logic        lower_irq_rising,
	input  wire logic [2:0]  lower_irq_route_jumper,
	input  wire logic [2:0]  higher_irq_route_jumper,
	output logic      [4:0]  lower_irq,
	output logic      [6:0]  higher_irq
);
	localparam logic [3:0] DIV_LAST = 4'(idc_pkg::BASE_DIV - 1);
	localparam int unsigned N = idc_pkg::CNT_N;
	localparam int unsigned CW = idc_pkg::CNT_W;

	typedef struct packed {
		logic                  ior_prev;
		logic                  iow_prev;
		logic [15:0]           iso_out;
		logic [15:0]           pln_out;
		logic [3:0]            div;
		logic [N-1:0][1:0]     rw;
		logic [N-1:0]          flip_w;
		logic [N-1:0]          flip_r;
		logic [N-1:0][CW-1:0]  hold;
		logic [N-1:0]          held;
		logic [7:0]            stage;
		logic [7:0]            rdata;
		logic                  oe_n;
		logic                  src_s1;
		logic                  src_s2;
		logic                  src_s3;
		logic [2:0]            src_fill;
		logic                  ck0_prev;
		logic [4:0]            lo_irq;
		logic [6:0]            hi_irq;
	} idc_state_t;

	idc_state_t s_q;
	idc_state_t s_d;

	logic [N-1:0][CW-1:0] cnt;
	logic [N-1:0]         term;
	logic [N-1:0]         armed;
	logic [N-1:0]         tick;
	logic [N-1:0]         gate;
	logic [N-1:0]         ld;
	logic [N-1:0][CW-1:0] ldv;
	logic                 hit;
	logic                 wr_go;
	logic                 rd_go;
	logic                 src;
	logic                 base_tick;

	function automatic logic [7:0] idc_route(input logic [2:0] idx, input logic fire);
		idc_route = fire ? (8'h01 << idx) : 8'h00;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Block decode, A9 forces 200h..3FFh
	// Switch compare, A9 high, 6'h20 is 300h
	assign hit = sa[idc_pkg::ADDR_SEL]
		&& (sa[idc_pkg::BASE_MSB:idc_pkg::BASE_LSB] == base_select_switch);
	// One byte per strobe falling edge
	assign wr_go = hit && !iow_n && s_q.iow_prev;
	assign rd_go = hit && !ior_n && s_q.ior_prev;

	always_comb begin
		case (lower_irq_source_jumper)
			2'h0: src = iso_in[0];
			2'h1: src = iso_in[1];
			2'h2: src = plain_in[0];
			2'h3: src = plain_in[1];
			default: src = 1'b0;
		endcase
	end

	assign base_tick = (s_q.div == DIV_LAST);
	assign tick[0] = free_counter_clk && !s_q.ck0_prev;
	assign gate[0] = free_counter_gate;
	assign tick[1] = term[2];
	assign tick[2] = base_tick;
	assign gate[1] = 1'b1;
	assign gate[2] = 1'b1;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [2:0]    ofs;
		logic [1:0]    sel;
		logic [CW-1:0] v;
		int unsigned   k;
		ofs = sa[2:0];
		sel = data_in[idc_pkg::CW_SEL_LSB +: 2];
		v = '0;
		k = 0;
		s_d = s_q;
		ld = '0;
		ldv = '0;
		s_d.ior_prev = ior_n;
		s_d.iow_prev = iow_n;
		s_d.div = base_tick ? 4'h0 : s_q.div + 4'h1;
		s_d.ck0_prev = free_counter_clk;
		s_d.oe_n = !(hit && !ior_n);
		if (wr_go) begin
			case (ofs)
				idc_pkg::OFS_ISO_LO: s_d.iso_out[7:0] = data_in;
				idc_pkg::OFS_ISO_HI: s_d.iso_out[15:8] = data_in;
				idc_pkg::OFS_PLN_LO: s_d.pln_out[7:0] = data_in;
				idc_pkg::OFS_PLN_HI: s_d.pln_out[15:8] = data_in;
				idc_pkg::OFS_CTRL: begin
					if (sel != idc_pkg::CW_READBACK) begin
						if (data_in[idc_pkg::CW_RW_LSB +: 2] == idc_pkg::RW_LATCH) begin
							s_d.hold[sel] = cnt[sel];
							s_d.held[sel] = 1'b1;
						end else begin
							s_d.rw[sel] = data_in[idc_pkg::CW_RW_LSB +: 2];
							s_d.flip_w[sel] = 1'b0;
							s_d.flip_r[sel] = 1'b0;
							s_d.held[sel] = 1'b0;
						end
					end
				end
				default: begin
					k = 32'(ofs - idc_pkg::OFS_CNT0);
					case (s_q.rw[k])
						idc_pkg::RW_LSB: begin
							ld[k] = 1'b1;
							ldv[k] = {8'h00, data_in};
						end
						idc_pkg::RW_MSB: begin
							ld[k] = 1'b1;
							ldv[k] = {data_in, 8'h00};
						end
						default: begin
							// Low byte waits in stage so a half load never starts counting
							if (!s_q.flip_w[k]) begin
								s_d.stage = data_in;
								s_d.flip_w[k] = 1'b1;
							end else begin
								ld[k] = 1'b1;
								ldv[k] = {data_in, s_q.stage};
								s_d.flip_w[k] = 1'b0;
							end
						end
					endcase
				end
			endcase
		end
		if (rd_go) begin
			case (ofs)
				idc_pkg::OFS_ISO_LO: s_d.rdata = iso_in[7:0];
				idc_pkg::OFS_ISO_HI: s_d.rdata = iso_in[15:8];
				idc_pkg::OFS_PLN_LO: s_d.rdata = plain_in[7:0];
				idc_pkg::OFS_PLN_HI: s_d.rdata = plain_in[15:8];
				idc_pkg::OFS_CTRL: s_d.rdata = {5'h00, armed};
				default: begin
					k = 32'(ofs - idc_pkg::OFS_CNT0);
					v = s_q.held[k] ? s_q.hold[k] : cnt[k];
					case (s_q.rw[k])
						idc_pkg::RW_LSB: begin
							s_d.rdata = v[7:0];
							s_d.held[k] = 1'b0;
						end
						idc_pkg::RW_MSB: begin
							s_d.rdata = v[15:8];
							s_d.held[k] = 1'b0;
						end
						default: begin
							s_d.rdata = s_q.flip_r[k] ? v[15:8] : v[7:0];
							if (s_q.flip_r[k]) begin
								s_d.held[k] = 1'b0;
							end
							s_d.flip_r[k] = !s_q.flip_r[k];
						end
					endcase
				end
			endcase
		end
		s_d.src_s1 = src;
		s_d.src_s2 = s_q.src_s1;
		s_d.src_s3 = s_q.src_s2;
		// No edge until the third flop holds a real pin sample
		s_d.src_fill = {s_q.src_fill[1:0], 1'b1};
		s_d.lo_irq = 5'(idc_route(lower_irq_route_jumper, s_q.src_fill[2]
			&& (lower_irq_rising ? (s_q.src_s2 && !s_q.src_s3) : (!s_q.src_s2 && s_q.src_s3))));
		// Own path, no gating by the lower line
		s_d.hi_irq = 7'(idc_route(higher_irq_route_jumper, term[1]));
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.ior_prev <= 1'b1;
			s_q.iow_prev <= 1'b1;
			s_q.oe_n <= 1'b1;
			s_q.rw <= {N{idc_pkg::RW_BOTH}};
		end else begin
			s_q <= s_d;
		end
	end

	for (genvar i = 0; i < N; i++) begin : g_cnt
		idc_counter #(.W(CW)) u_cnt (
			.mclk     (mclk),
			.nrst     (nrst),
			.tick     (tick[i]),
			.gate     (gate[i]),
			.load     (ld[i]),
			.load_val (ldv[i]),
			.count_q  (cnt[i]),
			.term_q   (term[i]),
			.armed_q  (armed[i])
		);
	end

	assign iso_out    = s_q.iso_out;
	assign plain_out  = s_q.pln_out;
	assign data_out   = s_q.rdata;
	assign data_oe_n  = s_q.oe_n;
	assign lower_irq  = s_q.lo_irq;
	assign higher_irq = s_q.hi_irq;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_A9_REQUIRED: assert property (!data_oe_n |-> $past(sa[9]))
		else $error("read driven without A9 high");
	AST_BASE_MATCH: assert property (!data_oe_n |-> $past(sa[8:3]) == $past(base_select_switch))
		else $error("read driven on base mismatch");
	AST_ISO_WRITE: assert property (wr_go && sa[2:0] == idc_pkg::OFS_ISO_LO |=> iso_out[7:0] == $past(data_in))
		else $error("isolated low byte not written");
	AST_PLAIN_READ: assert property (rd_go && sa[2:0] == idc_pkg::OFS_PLN_HI |=> data_out == $past(plain_in[15:8]))
		else $error("plain high byte read wrong");
	AST_BASE_PERIOD: assert property (base_tick |=> !base_tick [*8] ##1 !base_tick ##1 base_tick)
		else $error("counter two enable not 2 MHz");
	AST_CASCADE: assert property (term[1] |-> $past(term[2]))
		else $error("counter one stepped without counter two");
	AST_FREE_CLK: assert property (term[0] |-> $past(tick[0] && gate[0]))
		else $error("counter zero stepped without header clock");
	AST_HI_ROUTE: assert property (term[1] |=> higher_irq == 7'(8'h01 << $past(higher_irq_route_jumper)))
		else $error("timer interrupt not routed");
	AST_LO_ONE_PULSE: assert property (lower_irq != 5'h00 |=> lower_irq == 5'h00)
		else $error("lower interrupt longer than one cycle");
	AST_LO_EDGE: assert property (lower_irq != 5'h00 |-> $past(s_q.src_s2 != s_q.src_s3))
		else $error("lower interrupt without an edge");

	COV_BOTH_IRQ: cover property (lower_irq != 5'h00 && higher_irq != 7'h00);
	COV_DEFAULT_BASE: cover property (rd_go && base_select_switch == idc_pkg::SW_FACTORY);
	COV_CTRL_WRITE: cover property (wr_go && sa[2:0] == idc_pkg::OFS_CTRL);
	COV_PACER: cover property (term[1]);
endmodule
`default_nettype wire

/* verification/idc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module idc_host (
	input  wire logic       mclk,
	output logic      [9:0] sa,
	output logic            ior_n,
	output logic            iow_n,
	output logic      [7:0] data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe_n
);
	initial begin
		sa = 10'h000;
		ior_n = 1'b1;
		iow_n = 1'b1;
		data_in = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// One byte per strobe
	// Released lines show the inverse, not a stale value
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		sa <= a;
		data_in <= d;
		iow_n <= 1'b0;
		repeat (2) @(posedge mclk);
		iow_n <= 1'b1;
		data_in <= ~d;
		sa <= ~a;
		@(posedge mclk);
	endtask
	// Byte read, strobe high gap after
	task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic oe_n);
		@(posedge mclk);
		sa <= a;
		ior_n <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		d = data_out;
		oe_n = data_oe_n;
		@(posedge mclk);
		ior_n <= 1'b1;
		sa <= ~a;
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire

/* verification/isa_isolated_dio_card_core_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module isa_isolated_dio_card_core_bench;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic [9:0]  sa;
	logic        ior_n;
	logic        iow_n;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic        data_oe_n;
	logic [5:0]  sw = 6'h20;
	logic [15:0] iso_in = 16'h0000;
	logic [15:0] plain_in = 16'h0000;
	logic [15:0] iso_out;
	logic [15:0] plain_out;
	logic        fclk = 1'b0;
	logic        fgate = 1'b1;
	logic [1:0]  src = 2'h0;
	logic        rising = 1'b1;
	logic [2:0]  lroute = 3'h0;
	logic [2:0]  hroute = 3'h0;
	logic [4:0]  lower_irq;
	logic [6:0]  higher_irq;
	int          error_cnt = 0;
	int          cmp_count = 0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) fclk <= ~fclk;
	idc_host host_u (.mclk(mclk), .sa(sa), .ior_n(ior_n), .iow_n(iow_n), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n));
	idc_core dut_u (.mclk(mclk), .nrst(nrst), .sa(sa), .ior_n(ior_n), .iow_n(iow_n),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .base_select_switch(sw),
		.iso_in(iso_in), .plain_in(plain_in), .iso_out(iso_out), .plain_out(plain_out),
		.free_counter_clk(fclk), .free_counter_gate(fgate), .lower_irq_source_jumper(src),
		.lower_irq_rising(rising), .lower_irq_route_jumper(lroute),
		.higher_irq_route_jumper(hroute), .lower_irq(lower_irq), .higher_irq(higher_irq));
	function automatic logic [9:0] base_of(input logic [5:0] s);
		return {1'b1, s, 3'h0};
	endfunction
	task automatic summarize();
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Counts cycles with exactly the routed bit; stray bits weigh heavily
	task automatic watch(input int n, input logic hi, output int h);
		h = 0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (hi ? higher_irq === 7'(7'h01 << hroute) : lower_irq === 5'(5'h01 << lroute))
				h++;
			else if (hi ? higher_irq !== 7'h00 : lower_irq !== 5'h00)
				h += 100;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#(50 * 40000);
		error_cnt++;
		summarize();
	end
	initial begin
		logic [9:0]  a;
		logic [7:0]  w [4];
		logic [7:0]  d;
		logic        oe;
		int          h;
		logic [15:0] v16;
		logic [15:0] c16;
		void'($urandom(46));
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1;
		`CHK("reset outputs", 32'h0, {iso_out, plain_out})
		`CHK("reset oe", 1'b1, data_oe_n)
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			sw <= (i == 0) ? 6'h20 : 6'($urandom);
			iso_in <= 16'($urandom);
			plain_in <= 16'($urandom);
			@(posedge mclk);
			// Factory setting must answer at 300h
			a = (i == 0) ? 10'h300 : base_of(sw);
			for (int k = 0; k < 4; k++) begin
				w[k] = 8'($urandom);
				host_u.wr(a + 10'(k), w[k]);
			end
			`CHK("iso out", {w[1], w[0]}, iso_out)
			`CHK("plain out", {w[3], w[2]}, plain_out)
			for (int k = 0; k < 4; k++) begin
				host_u.rd(a + 10'(k), d, oe);
				`CHK("input byte", 8'({plain_in, iso_in} >> (8 * k)), d)
				`CHK("read oe", 1'b0, oe)
			end
			host_u.wr({1'b0, a[8:0]}, ~w[0]);
			`CHK("A9 low ignored", w[0], iso_out[7:0])
			host_u.wr({1'b1, a[8:3] ^ 6'(6'h01 << (i % 6)), 3'h2}, ~w[2]);
			`CHK("switch mismatch ignored", w[2], plain_out[7:0])
			host_u.rd({1'b0, a[8:0]}, d, oe);
			`CHK("unselected oe", 1'b1, oe)
		end
		// Counter zero holds with header gate low
		fgate <= 1'b0;
		v16 = 16'($urandom) | 16'h0100;
		host_u.wr(a + 10'h7, 8'h30);
		host_u.wr(a + 10'h4, v16[7:0]);
		host_u.wr(a + 10'h4, v16[15:8]);
		host_u.rd(a + 10'h4, d, oe);
		`CHK("count low byte", v16[7:0], d)
		host_u.rd(a + 10'h4, d, oe);
		`CHK("count high byte", v16[15:8], d)
		// Header clock rises every second mclk while the gate is open
		fgate <= 1'b1;
		repeat (20) @(posedge mclk);
		fgate <= 1'b0;
		host_u.wr(a + 10'h7, 8'h00);
		host_u.rd(a + 10'h4, d, oe);
		c16[7:0] = d;
		host_u.rd(a + 10'h4, d, oe);
		c16[15:8] = d;
		`CHK("header clock count", 1'b1, c16 <= v16 - 16'd9 && c16 >= v16 - 16'd11)
		@(posedge mclk);
		hroute <= 3'($urandom_range(0, 6));
		host_u.wr(a + 10'h7, 8'h50);
		host_u.wr(a + 10'h5, 8'h02);
		host_u.wr(a + 10'h7, 8'h90);
		host_u.wr(a + 10'h6, 8'h03);
		host_u.rd(a + 10'h7, d, oe);
		`CHK("armed status", 8'h07, d)
		// Pacer period is 10 * 3 * 2 mclk
		watch(600, 1'b1, h);
		`CHK("pacer pulses", 1'b1, h >= 9 && h <= 11)
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 2; p++) begin
				@(posedge mclk);
				src <= 2'(s);
				rising <= p[0];
				lroute <= 3'($urandom_range(0, 4));
				iso_in[1:0] <= {2{~p[0]}};
				plain_in[1:0] <= {2{~p[0]}};
				repeat (8) @(posedge mclk);
				if (s < 2)
					iso_in[s] <= p[0];
				else
					plain_in[s - 2] <= p[0];
				watch(10, 1'b0, h);
				`CHK("selected edge pulses", 1, h)
				@(posedge mclk);
				iso_in[1:0] <= {2{~p[0]}};
				plain_in[1:0] <= {2{~p[0]}};
				watch(10, 1'b0, h);
				`CHK("opposite edge pulses", 0, h)
			end
		end
		// Timer keeps running beside the edge source
		watch(130, 1'b1, h);
		`CHK("pacer alongside", 1'b1, h >= 2 && h <= 3)
		summarize();
	end
endmodule
`default_nettype wire
